// ---- rtl/sfpc_pkg.sv ----
/*
 sfpc_pkg: constants for the serial flash program control block.
 assumes one link clock from the programmer and one core clock.
*/
package sfpc_pkg;
   // link control codes, lsb first on the wire
   localparam logic [3:0] CODE_EXEC = 4'h0;
   localparam logic [3:0] CODE_READOUT = 4'h1;
   // last bit index of each link phase
   localparam logic [4:0] CNT_CODE_LAST = 5'h03;
   localparam logic [4:0] CNT_INSTR_LAST = 5'h17;
   localparam logic [4:0] CNT_PROC_LAST = 5'h07;
   localparam logic [4:0] CNT_SHIFT_LAST = 5'h0F;
   localparam int CODE_W = 4;
   localparam int INSTR_W = 24;
   localparam int VIS_W = 16;
   // control register, visible value reset and unlock keys
   localparam int START_BIT = 15;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] VIS_RESET = 16'h0000;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // executed instruction opcodes, instruction bits 23:16
   localparam logic [7:0] INS_WR_CTRL = 8'h01;
   localparam logic [7:0] INS_WR_KEY = 8'h02;
   localparam logic [7:0] INS_SET_START = 8'h03;
   localparam logic [7:0] INS_CLR_START = 8'h04;
   localparam logic [7:0] INS_LD_VIS = 8'h05;
   localparam logic [7:0] INS_RD_CTRL = 8'h06;
   // control values for erase and write
   localparam logic [15:0] OP_ERASE_ALL = 16'h407F;
   localparam logic [15:0] OP_ERASE_EE_ROW = 16'h4075;
   localparam logic [15:0] OP_ERASE_EE_WORD = 16'h4074;
   localparam logic [15:0] OP_ERASE_EXEC = 16'h4072;
   localparam logic [15:0] OP_ERASE_CODE_ROW = 16'h4071;
   localparam logic [15:0] OP_ERASE_BSG = 16'h406E;
   localparam logic [15:0] OP_ERASE_SG = 16'h405E;
   localparam logic [15:0] OP_ERASE_G = 16'h404E;
   localparam logic [15:0] OP_ERASE_EE_B = 16'h4066;
   localparam logic [15:0] OP_ERASE_EE_S = 16'h4056;
   localparam logic [15:0] OP_ERASE_EE_G = 16'h4046;
   localparam logic [15:0] OP_WR_CONFIG = 16'h4008;
   localparam logic [15:0] OP_WR_DATA_ROW = 16'h4005;
   localparam logic [15:0] OP_WR_DATA_WORD = 16'h4004;
   localparam logic [15:0] OP_WR_CODE_ROW = 16'h4001;
   // operation kind reported while a cycle runs
   typedef enum logic [3:0] {
      OPK_NONE = 4'h0, OPK_ERASE_ALL = 4'h1, OPK_ERASE_EE_ROW = 4'h2,
      OPK_ERASE_EE_WORD = 4'h3, OPK_ERASE_EXEC = 4'h4, OPK_ERASE_CODE_ROW = 4'h5,
      OPK_ERASE_BSG = 4'h6, OPK_ERASE_SG = 4'h7, OPK_ERASE_G = 4'h8,
      OPK_ERASE_EE_B = 4'h9, OPK_ERASE_EE_S = 4'hA, OPK_ERASE_EE_G = 4'hB,
      OPK_WR_CONFIG = 4'hC, OPK_WR_DATA_ROW = 4'hD, OPK_WR_DATA_WORD = 4'hE,
      OPK_WR_CODE_ROW = 4'hF
   } sfpc_opk_t;
   typedef enum logic [3:0] {
      LS_CODE = 4'b0001, LS_INSTR = 4'b0010, LS_PROC = 4'b0100, LS_SHIFT = 4'b1000
   } sfpc_lstate_t;
   typedef enum logic [2:0] {
      KEY_LOCKED = 3'b001, KEY_HALF = 3'b010, KEY_OPEN = 3'b100
   } sfpc_key_t;
endpackage

// ---- rtl/sfpc_sync.sv ----
/*
 sfpc_sync: two-flop synchroniser, W bits wide.
 assumes each bit is a level or a held value, stable for many cycles.
*/
`timescale 1ns/10ps
module sfpc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge clk) begin
      meta_reg <= d;
      q_reg <= meta_reg;
   end

   assign q = q_reg;
endmodule

// ---- rtl/sfpc_nvm.sv ----
/*
 sfpc_nvm: memory control register, unlock key and start bit.
 assumes insValid is a one-cycle pulse with insWord stable in core_clk.
*/
`timescale 1ns/10ps
module sfpc_nvm
   import sfpc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic insValid,
   input wire logic [23:0] insWord,
   output logic [15:0] ctrl,
   output logic active,
   output logic [3:0] opKind
);
   logic [15:0] ctrl_reg, ctrl_next;
   sfpc_opk_t opk_reg, opk_next;
   sfpc_key_t key_reg, key_next;
   logic [7:0] op;
   sfpc_opk_t decoded;

   assign op = insWord[23:16];

   always_comb begin
      case (ctrl_reg & 16'h7FFF | 16'h0000)
         OP_ERASE_ALL: decoded = OPK_ERASE_ALL;
         OP_ERASE_EE_ROW: decoded = OPK_ERASE_EE_ROW;
         OP_ERASE_EE_WORD: decoded = OPK_ERASE_EE_WORD;
         OP_ERASE_EXEC: decoded = OPK_ERASE_EXEC;
         OP_ERASE_CODE_ROW: decoded = OPK_ERASE_CODE_ROW;
         OP_ERASE_BSG: decoded = OPK_ERASE_BSG;
         OP_ERASE_SG: decoded = OPK_ERASE_SG;
         OP_ERASE_G: decoded = OPK_ERASE_G;
         OP_ERASE_EE_B: decoded = OPK_ERASE_EE_B;
         OP_ERASE_EE_S: decoded = OPK_ERASE_EE_S;
         OP_ERASE_EE_G: decoded = OPK_ERASE_EE_G;
         OP_WR_CONFIG: decoded = OPK_WR_CONFIG;
         OP_WR_DATA_ROW: decoded = OPK_WR_DATA_ROW;
         OP_WR_DATA_WORD: decoded = OPK_WR_DATA_WORD;
         OP_WR_CODE_ROW: decoded = OPK_WR_CODE_ROW;
         default: decoded = OPK_NONE;
      endcase
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      opk_next = opk_reg;
      key_next = key_reg;
      if (insValid) begin
         case (op)
            INS_WR_KEY: begin
               if (key_reg == KEY_LOCKED && insWord[7:0] == KEY_FIRST) begin
                  key_next = KEY_HALF;
               end else if (key_reg == KEY_HALF && insWord[7:0] == KEY_SECOND) begin
                  key_next = KEY_OPEN;
               end else begin
                  key_next = KEY_LOCKED;
               end
            end
            INS_WR_CTRL: begin
               if (!ctrl_reg[START_BIT]) begin
                  ctrl_next[14:0] = insWord[14:0];
               end
            end
            INS_SET_START: begin
               if (key_reg == KEY_OPEN && !ctrl_reg[START_BIT] && decoded != OPK_NONE) begin
                  ctrl_next[START_BIT] = 1'b1;
                  opk_next = decoded;
               end
               key_next = KEY_LOCKED;
            end
            INS_CLR_START: begin
               // clear ends the cycle, timed outside
               ctrl_next[START_BIT] = 1'b0;
               opk_next = OPK_NONE;
            end
            default: begin
               ctrl_next = ctrl_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= CTRL_RESET;
         opk_reg <= OPK_NONE;
         key_reg <= KEY_LOCKED;
      end else begin
         ctrl_reg <= ctrl_next;
         opk_reg <= opk_next;
         key_reg <= key_next;
      end
   end

   assign ctrl = ctrl_reg;
   assign active = ctrl_reg[START_BIT];
   assign opKind = opk_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_locked_ignored;
      insValid && op == INS_SET_START && key_reg != KEY_OPEN && !ctrl_reg[START_BIT]
         |=> !ctrl_reg[START_BIT];
   endproperty
   a_locked_ignored: assert property (p_locked_ignored)
      else $error("start set without unlock");

   property p_start;
      insValid && op == INS_SET_START && key_reg == KEY_OPEN && decoded != OPK_NONE
         |=> ctrl_reg[START_BIT] && opk_reg == $past(decoded);
   endproperty
   a_start: assert property (p_start)
      else $error("unlocked start did not begin cycle");

   property p_stop;
      insValid && op == INS_CLR_START |=> !ctrl_reg[START_BIT] ##0 opk_reg == OPK_NONE;
   endproperty
   a_stop: assert property (p_stop)
      else $error("clear did not end cycle");

   property p_unlock;
      insValid && op == INS_WR_KEY && insWord[7:0] == KEY_SECOND && key_reg == KEY_HALF
         |=> key_reg == KEY_OPEN;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("key pair did not unlock");

   property p_op_valid;
      ctrl_reg[START_BIT] |-> opk_reg != OPK_NONE && opk_reg == decoded;
   endproperty
   a_op_valid: assert property (p_op_valid)
      else $error("cycle running with no decoded operation");

   c_start: cover property (insValid && op == INS_SET_START ##1 ctrl_reg[START_BIT]);
endmodule

// ---- rtl/sfpc_top.sv ----
/*
 sfpc_top: serial programming link and flash control for the device.
 assumes progClk comes from the programmer and may stop between frames;
 core_clk runs free at 100 MHz; reset is synchronous to core_clk.
*/
`timescale 1ns/10ps
module sfpc_top
   import sfpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic progClk,
   input wire logic progDataIn,
   output logic progDataOut,
   output logic progDataOe,
   output logic cpuIdle,
   output logic nvmActive,
   output logic [3:0] nvmOpKind,
   output logic [15:0] nvmCtrl
);
   // link domain state
   sfpc_lstate_t lstate_reg, lstate_next;
   logic [4:0] bitCnt_reg, bitCnt_next;
   logic [INSTR_W-1:0] shiftIn_reg, shiftIn_next;
   logic [INSTR_W-1:0] insWord_reg, insWord_next;
   logic insTgl_reg, insTgl_next;
   logic execPend_reg, execPend_next;
   logic [VIS_W-1:0] visShift_reg, visShift_next;
   logic [CODE_W-1:0] code;
   logic progDataOut_reg, progDataOut_next;
   logic progDataOe_reg, progDataOe_next;
   logic linkRst;
   logic [VIS_W-1:0] visLink;

   // core domain state
   logic insTglS, insTglD_reg;
   logic insValid_reg, insValid_next;
   logic [INSTR_W-1:0] capWord_reg, capWord_next;
   logic [VIS_W-1:0] visReg_reg, visReg_next;
   logic execPendS;
   logic cpuIdle_reg, cpuIdle_next;
   logic nvmActiveW;
   logic [3:0] nvmOpKindW;
   logic [15:0] nvmCtrlW;

   // reset reaches the link only while progClk runs
   sfpc_sync #(.W(1)) u_rst_sync (
      .clk(progClk),
      .d(reset),
      .q(linkRst)
   );

   // visible value is quasi-static: loaded by a finished instruction,
   // read by the link eight clocks after the read-out code at the soonest
   sfpc_sync #(.W(VIS_W)) u_vis_sync (
      .clk(progClk),
      .d(visReg_reg),
      .q(visLink)
   );

   // lsb first, shift in on falling edge
   always_comb begin
      shiftIn_next = {progDataIn, shiftIn_reg[INSTR_W-1:1]};
      code = shiftIn_next[INSTR_W-1 -: CODE_W];
   end

   always_comb begin
      lstate_next = lstate_reg;
      bitCnt_next = bitCnt_reg + 5'h01;
      insWord_next = insWord_reg;
      insTgl_next = insTgl_reg;
      execPend_next = execPend_reg;
      visShift_next = visShift_reg;
      case (lstate_reg)
         LS_CODE: begin
            if (bitCnt_reg == CNT_CODE_LAST) begin
               bitCnt_next = 5'h00;
               // execution of last instruction ends with the code
               execPend_next = 1'b0;
               if (code == CODE_EXEC) begin
                  lstate_next = LS_INSTR;
               end else if (code == CODE_READOUT) begin
                  lstate_next = LS_PROC;
               end else begin
                  lstate_next = LS_CODE;
               end
            end
         end
         LS_INSTR: begin
            if (bitCnt_reg == CNT_INSTR_LAST) begin
               bitCnt_next = 5'h00;
               insWord_next = shiftIn_next;
               // word is held 28 link clocks, far longer than the crossing
               insTgl_next = ~insTgl_reg;
               execPend_next = 1'b1;
               lstate_next = LS_CODE;
            end
         end
         LS_PROC: begin
            if (bitCnt_reg == CNT_PROC_LAST) begin
               bitCnt_next = 5'h00;
               visShift_next = visLink;
               lstate_next = LS_SHIFT;
            end
         end
         LS_SHIFT: begin
            visShift_next = {1'b0, visShift_reg[VIS_W-1:1]};
            if (bitCnt_reg == CNT_SHIFT_LAST) begin
               bitCnt_next = 5'h00;
               lstate_next = LS_CODE;
            end
         end
         default: begin
            bitCnt_next = 5'h00;
            lstate_next = LS_CODE;
         end
      endcase
   end

   always_ff @(negedge progClk) begin
      if (linkRst) begin
         lstate_reg <= LS_CODE;
         bitCnt_reg <= 5'h00;
         shiftIn_reg <= '0;
         insWord_reg <= '0;
         insTgl_reg <= 1'b0;
         execPend_reg <= 1'b0;
         visShift_reg <= VIS_RESET;
      end else begin
         lstate_reg <= lstate_next;
         bitCnt_reg <= bitCnt_next;
         shiftIn_reg <= shiftIn_next;
         insWord_reg <= insWord_next;
         insTgl_reg <= insTgl_next;
         execPend_reg <= execPend_next;
         visShift_reg <= visShift_next;
      end
   end

   // drive only during shift-out; release on next rising edge
   always_comb begin
      progDataOe_next = (lstate_reg == LS_SHIFT);
      progDataOut_next = progDataOe_next ? visShift_reg[0] : 1'b0;
   end

   always_ff @(posedge progClk) begin
      if (linkRst) begin
         progDataOe_reg <= 1'b0;
         progDataOut_reg <= 1'b0;
      end else begin
         progDataOe_reg <= progDataOe_next;
         progDataOut_reg <= progDataOut_next;
      end
   end

   // core side of the instruction handshake
   sfpc_sync #(.W(2)) u_core_sync (
      .clk(core_clk),
      .d({insTgl_reg, execPend_reg}),
      .q({insTglS, execPendS})
   );

   always_comb begin
      insValid_next = insTglS ^ insTglD_reg;
      capWord_next = insValid_next ? insWord_reg : capWord_reg;
      // cpu runs only while an instruction executes
      cpuIdle_next = ~execPendS;
      visReg_next = visReg_reg;
      if (insValid_reg && capWord_reg[23:16] == INS_LD_VIS) begin
         visReg_next = capWord_reg[15:0];
      end else if (insValid_reg && capWord_reg[23:16] == INS_RD_CTRL) begin
         visReg_next = nvmCtrlW;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         insTglD_reg <= 1'b0;
         insValid_reg <= 1'b0;
         capWord_reg <= '0;
         visReg_reg <= VIS_RESET;
         cpuIdle_reg <= 1'b1;
      end else begin
         insTglD_reg <= insTglS;
         insValid_reg <= insValid_next;
         capWord_reg <= capWord_next;
         visReg_reg <= visReg_next;
         cpuIdle_reg <= cpuIdle_next;
      end
   end

   // start bit control, cycle timed by programmer
   sfpc_nvm u_nvm (
      .clk(core_clk),
      .reset(reset),
      .insValid(insValid_reg),
      .insWord(capWord_reg),
      .ctrl(nvmCtrlW),
      .active(nvmActiveW),
      .opKind(nvmOpKindW)
   );

   assign progDataOut = progDataOut_reg;
   assign progDataOe = progDataOe_reg;
   assign cpuIdle = cpuIdle_reg;
   assign nvmActive = nvmActiveW;
   assign nvmOpKind = nvmOpKindW;
   assign nvmCtrl = nvmCtrlW;

   property p_proc_len;
      @(negedge progClk) disable iff (linkRst)
      lstate_reg == LS_CODE && bitCnt_reg == CNT_CODE_LAST && code == CODE_READOUT
         |=> (lstate_reg == LS_PROC)[*8] ##1 lstate_reg == LS_SHIFT;
   endproperty
   a_proc_len: assert property (p_proc_len)
      else $error("read-out processing not eight clocks");

   property p_shift_len;
      @(negedge progClk) disable iff (linkRst)
      lstate_reg == LS_SHIFT && bitCnt_reg != CNT_SHIFT_LAST
         |=> lstate_reg == LS_SHIFT && bitCnt_reg == $past(bitCnt_reg) + 5'h01;
   endproperty
   a_shift_len: assert property (p_shift_len)
      else $error("shift-out broke before sixteen bits");

   property p_shift_end;
      @(negedge progClk) disable iff (linkRst)
      lstate_reg == LS_SHIFT && bitCnt_reg == CNT_SHIFT_LAST |=> lstate_reg == LS_CODE;
   endproperty
   a_shift_end: assert property (p_shift_end)
      else $error("no return to code reception after shift-out");

   property p_input_dir;
      @(posedge progClk) disable iff (linkRst)
      lstate_reg != LS_SHIFT |=> !progDataOe_reg;
   endproperty
   a_input_dir: assert property (p_input_dir)
      else $error("data pin driven outside shift-out");

   property p_bit_out;
      @(posedge progClk) disable iff (linkRst)
      lstate_reg == LS_SHIFT |=> progDataOe_reg && progDataOut_reg == $past(visShift_reg[0]);
   endproperty
   a_bit_out: assert property (p_bit_out)
      else $error("wrong bit or pin released during shift-out");

   property p_reserved;
      @(negedge progClk) disable iff (linkRst)
      lstate_reg == LS_CODE && bitCnt_reg == CNT_CODE_LAST && code > CODE_READOUT
         |=> lstate_reg == LS_CODE && bitCnt_reg == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved code not ignored");

   c_readout: cover property (@(negedge progClk) lstate_reg == LS_SHIFT ##1 lstate_reg == LS_CODE);
   c_exec: cover property (@(posedge core_clk) insValid_reg ##1 !cpuIdle_reg);
   c_release: cover property (@(posedge progClk) progDataOe_reg ##1 !progDataOe_reg);
endmodule

// ---- verif/sfpc_prog.sv ----
/*
 sfpc_prog: behavioural model of the external programmer on the link.
 assumes the device drives the data pin only while progDataOe is high.
*/
`timescale 1ns/10ps
module sfpc_prog #(
   parameter int WAIT_NS = 2000000
) (
   output logic progClk,
   output logic progDataIn,
   input wire logic progDataOut,
   input wire logic progDataOe
);
   logic drvVal = 1'b0;
   initial progClk = 1'b0;
   // no pull on the pin, so a released line toggles to expose stale reads
   assign progDataIn = progDataOe ? progDataOut : drvVal;

   // change after rise, sample on fall
   task automatic link_bit(input logic b, input logic drive, output logic seen,
      output logic oe);
      progClk = 1'b1;
      #1;
      drvVal = drive ? b : ~drvVal;
      #39;
      progClk = 1'b0;
      seen = progDataIn;
      oe = progDataOe;
      #40;
   endtask

   task automatic send_bits(input logic [23:0] v, input int n, input logic drive,
      output logic [23:0] got, output logic [23:0] oes);
      for (int i = 0; i < n; i++) begin
         link_bit(v[i], drive, got[i], oes[i]);
      end
   endtask

   task automatic send_code(input logic [3:0] c);
      logic [23:0] g, o;
      send_bits({20'h00000, c}, 4, 1'b1, g, o);
   endtask

   task automatic send_instr(input logic [7:0] op, input logic [15:0] d);
      logic [23:0] g, o;
      send_bits(24'h000000, 4, 1'b1, g, o);
      send_bits({op, d}, 24, 1'b1, g, o);
   endtask

   task automatic readout(output logic [15:0] val, output logic [27:0] oes);
      logic [23:0] g, o;
      send_bits(24'h000001, 4, 1'b1, g, o);
      oes[3:0] = o[3:0];
      send_bits(24'h000000, 8, 1'b0, g, o);
      oes[11:4] = o[7:0];
      send_bits(24'h000000, 16, 1'b0, g, o);
      oes[27:12] = o[15:0];
      val = g[15:0];
   endtask

   task automatic idle(input int n);
      logic [23:0] g, o;
      send_bits(24'h000000, n, 1'b0, g, o);
   endtask

   task automatic timed_wait();
      #(WAIT_NS);
   endtask
endmodule

// ---- verif/tb.sv ----
/*
 tb: self-checking bench for sfpc_top with the programmer model.
 assumes core-side updates land within 100 ns after an instruction ends.
*/
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
   $display("[FAIL] %s exp %0h got %0h", nm, (exp), (got)); end end
module tb;
   import sfpc_pkg::*;
   typedef struct {logic [15:0] ctrl; logic [3:0] kind;} sfpc_row_t;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic progClk, progDataIn, progDataOut, progDataOe, cpuIdle, nvmActive;
   logic [3:0] nvmOpKind;
   logic [15:0] nvmCtrl, val;
   logic [27:0] oes;
   int num_errors = 0;
   int compares = 0;
   // erase rows come before write rows
   sfpc_row_t rows[15] = '{'{OP_ERASE_ALL, 4'h1}, '{OP_ERASE_EE_ROW, 4'h2},
      '{OP_ERASE_EE_WORD, 4'h3}, '{OP_ERASE_EXEC, 4'h4}, '{OP_ERASE_CODE_ROW, 4'h5},
      '{OP_ERASE_BSG, 4'h6}, '{OP_ERASE_SG, 4'h7}, '{OP_ERASE_G, 4'h8},
      '{OP_ERASE_EE_B, 4'h9}, '{OP_ERASE_EE_S, 4'hA}, '{OP_ERASE_EE_G, 4'hB},
      '{OP_WR_CONFIG, 4'hC}, '{OP_WR_DATA_ROW, 4'hD}, '{OP_WR_DATA_WORD, 4'hE},
      '{OP_WR_CODE_ROW, 4'hF}};

   always #5 core_clk = ~core_clk;

   sfpc_top sfpc_top_i(.core_clk(core_clk), .reset(reset), .progClk(progClk),
      .progDataIn(progDataIn), .progDataOut(progDataOut), .progDataOe(progDataOe),
      .cpuIdle(cpuIdle), .nvmActive(nvmActive), .nvmOpKind(nvmOpKind), .nvmCtrl(nvmCtrl));
   // shortened wait keeps the run inside the cycle budget
   sfpc_prog #(.WAIT_NS(10000)) sfpc_prog_i(.progClk(progClk), .progDataIn(progDataIn),
      .progDataOut(progDataOut), .progDataOe(progDataOe));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // link reset is synchronised, so the link clock runs during reset
   task automatic do_reset();
      @(posedge core_clk) reset <= 1'b1;
      @(posedge core_clk);
      sfpc_prog_i.idle(3);
      `CHK("rst oe", progDataOe, 1'b0)
      `CHK("rst idle", cpuIdle, 1'b1)
      `CHK("rst active", nvmActive, 1'b0)
      `CHK("rst ctrl", nvmCtrl, CTRL_RESET)
      @(posedge core_clk) reset <= 1'b0;
      // the sync clears on the second rising edge, inside the first code bit; more would be taken as code bits
      @(posedge core_clk);
      sfpc_prog_i.idle(1);
   endtask

   task automatic cmd(input logic [7:0] op, input logic [15:0] d);
      sfpc_prog_i.send_instr(op, d);
      #100;
   endtask

   task automatic unlock();
      cmd(INS_WR_KEY, {8'h00, KEY_FIRST});
      cmd(INS_WR_KEY, {8'h00, KEY_SECOND});
   endtask

   initial begin
      // tests need about 400 us
      #800000;
      num_errors++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      do_reset();
      foreach (rows[i]) begin
         cmd(INS_WR_CTRL, rows[i].ctrl);
         unlock();
         cmd(INS_SET_START, 16'h0000);
         `CHK("start", nvmActive, 1'b1)
         `CHK("kind", nvmOpKind, rows[i].kind)
         `CHK("ctrl", nvmCtrl, {1'b1, rows[i].ctrl[14:0]})
         sfpc_prog_i.timed_wait();
         cmd(INS_CLR_START, 16'h0000);
         `CHK("stop", nvmActive, 1'b0)
         `CHK("stop kind", nvmOpKind, 4'h0)
      end
      $display("test table done");
      cmd(INS_WR_CTRL, OP_ERASE_EE_WORD);
      cmd(INS_SET_START, 16'h0000);
      `CHK("no key", nvmActive, 1'b0)
      `CHK("no key ctrl", nvmCtrl, OP_ERASE_EE_WORD)
      cmd(INS_WR_KEY, {8'h00, KEY_SECOND});
      cmd(INS_WR_KEY, {8'h00, KEY_FIRST});
      cmd(INS_SET_START, 16'h0000);
      `CHK("key swapped", nvmActive, 1'b0)
      cmd(INS_WR_KEY, {8'h00, KEY_FIRST});
      cmd(INS_WR_KEY, 16'h0012);
      cmd(INS_WR_KEY, {8'h00, KEY_SECOND});
      cmd(INS_SET_START, 16'h0000);
      `CHK("key broken", nvmActive, 1'b0)
      unlock();
      cmd(INS_SET_START, 16'h0000);
      cmd(INS_CLR_START, 16'h0000);
      cmd(INS_SET_START, 16'h0000);
      `CHK("relocked", nvmActive, 1'b0)
      $display("test lock done");
      cmd(INS_LD_VIS, 16'hA5C3);
      `CHK("exec run", cpuIdle, 1'b0)
      fork
         sfpc_prog_i.readout(val, oes);
         begin
            #840;
            `CHK("proc idle", cpuIdle, 1'b1)
         end
      join
      `CHK("vis", val, 16'hA5C3)
      `CHK("oe walk", oes, 28'hFFFF000)
      `CHK("oe held", progDataOe, 1'b1)
      `CHK("post idle", cpuIdle, 1'b1)
      fork
         cmd(INS_WR_CTRL, OP_WR_CODE_ROW);
         begin
            #20;
            `CHK("oe release", progDataOe, 1'b0)
         end
      join
      cmd(INS_RD_CTRL, 16'h0000);
      for (int c = 2; c < 16; c++) begin
         sfpc_prog_i.send_code(c[3:0]);
      end
      sfpc_prog_i.readout(val, oes);
      `CHK("after reserved", val, OP_WR_CODE_ROW)
      sfpc_prog_i.readout(val, oes);
      `CHK("back to back", val, OP_WR_CODE_ROW)
      `CHK("oe walk 2", oes, 28'hFFFF000)
      $display("test readout done");
      cmd(INS_WR_CTRL, OP_ERASE_G);
      unlock();
      cmd(INS_SET_START, 16'h0000);
      `CHK("mid start", nvmActive, 1'b1)
      do_reset();
      sfpc_prog_i.readout(val, oes);
      `CHK("post reset vis", val, VIS_RESET)
      `CHK("post reset oe", oes, 28'hFFFF000)
      $display("test reset done");
      tally_and_finish();
   end
endmodule
